// file: ctu_pkg.sv
// constants, encodings and reset values for the sixteen-channel capture/compare unit
// What this block does
// - sixteen channels; resolution one clock, or eight clocks when staggered.
// - two 16-bit timers, each with a reload register, as time bases.
// - timer count clock from prescaled system clock or auxiliary timer overflows.
// - a timer may instead count pulses on an external count input.
// - sixteen channel registers, each assigned to either timer, capture or compare.
// - each channel owns one pin: trigger input in capture, event output in compare modes 1 and 3 and, for a lower pair member, double-register mode.
// - on its trigger edge a capturing channel copies its timer into its register.
// - every capture raises that channel's interrupt request.
// - capture trigger per channel: rising, falling or either edge.
// - compare channels check their register against their timer on every count.
// - compare mode 0 raises only the interrupt, many per period, pin untouched.
// - compare mode 1 toggles the pin on every match, many per period.
// - compare mode 2 raises only the interrupt, at most once per period.
// - compare mode 3 sets pin on match, clears it on overflow, once per period.
// - double-register mode: two channels toggle one pin, many events per period.
// - single-event option with any compare mode gives just one edge or pulse.
package ctu_pkg;
    localparam int CTU_NUM_CH = 16;
    localparam int CTU_NUM_TMR = 2;
    localparam int CTU_TW = 16;
    localparam int CTU_PAIR_OFS = 8;
    localparam int CTU_PRE_W = 10;

    localparam logic [15:0] CTU_TMR_RST = 16'h0000;
    localparam logic [15:0] CTU_TMR_MAX = 16'hffff;
    localparam logic [15:0] CTU_CH_RST = 16'h0000;

    // channel modes
    localparam logic [2:0] CTU_MODE_OFF = 3'h0;
    localparam logic [2:0] CTU_MODE_CAPTURE = 3'h1;
    localparam logic [2:0] CTU_MODE_CMP0 = 3'h2;
    localparam logic [2:0] CTU_MODE_CMP1 = 3'h3;
    localparam logic [2:0] CTU_MODE_CMP2 = 3'h4;
    localparam logic [2:0] CTU_MODE_CMP3 = 3'h5;
    localparam logic [2:0] CTU_MODE_DOUBLE = 3'h6;

    // capture edge selection
    localparam logic [1:0] CTU_EDGE_NONE = 2'h0;
    localparam logic [1:0] CTU_EDGE_RISE = 2'h1;
    localparam logic [1:0] CTU_EDGE_FALL = 2'h2;
    localparam logic [1:0] CTU_EDGE_BOTH = 2'h3;

    // timer count sources
    localparam logic [1:0] CTU_SRC_PRESC = 2'h0;
    localparam logic [1:0] CTU_SRC_AUX = 2'h1;
    localparam logic [1:0] CTU_SRC_EXT = 2'h2;

    // staggered operation stretches the prescaler period by a factor of 2^3 = eight
    localparam logic [3:0] CTU_STAGGER_SHIFT = 4'h3;
    localparam logic [2:0] CTU_STAGGER_PHASE = 3'h7;
endpackage

// file: ctu_timer.sv
// one reloadable 16-bit time base of the capture/compare unit
`timescale 1ns/1ps
module ctu_timer (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic run_in,
    input wire logic tick_in,
    input wire logic wr_in,
    input wire logic [ctu_pkg::CTU_TW-1:0] wr_data_in,
    input wire logic [ctu_pkg::CTU_TW-1:0] reload_in,
    output logic [ctu_pkg::CTU_TW-1:0] val_out,
    output logic upd_out,
    output logic ovf_out
);
    import ctu_pkg::*;

    logic [CTU_TW-1:0] val_q;
    logic upd_q;
    logic ovf_q;
    logic step;

    assign step = run_in && tick_in && !wr_in;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            val_q <= CTU_TMR_RST;
        end else if (ce_in) begin
            if (wr_in) begin
                val_q <= wr_data_in;
            end else if (step) begin
                if (val_q == CTU_TMR_MAX) begin
                    val_q <= reload_in;
                end else begin
                    val_q <= val_q + 16'h0001;
                end
            end
        end
    end

    // upd marks the cycle in which the new count is visible to the comparators
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            upd_q <= 1'b0;
            ovf_q <= 1'b0;
        end else if (ce_in) begin
            upd_q <= step;
            ovf_q <= step && (val_q == CTU_TMR_MAX);
        end
    end

    assign val_out = val_q;
    assign upd_out = upd_q;
    assign ovf_out = ovf_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_reload_on_ovf: assert property (
        (ce_in && step && val_q == CTU_TMR_MAX) |=> (ovf_q && val_q == $past(reload_in)))
        else $error("timer did not reload on overflow");

    a_count_step: assert property (
        (ce_in && step && val_q != CTU_TMR_MAX) |=> (upd_q && val_q == $past(val_q) + 16'h0001))
        else $error("timer did not advance by one");
endmodule

// file: ctu_capture_compare.sv
// sixteen-channel capture/compare unit with two reloadable time bases
`timescale 1ns/1ps
module ctu_capture_compare (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic stagger_in,
    input wire logic [ctu_pkg::CTU_NUM_TMR-1:0] tmr_run_in,
    input wire logic [ctu_pkg::CTU_NUM_TMR-1:0][1:0] tmr_src_in,
    input wire logic [ctu_pkg::CTU_NUM_TMR-1:0][2:0] tmr_presc_in,
    input wire logic [ctu_pkg::CTU_NUM_TMR-1:0][ctu_pkg::CTU_TW-1:0] tmr_reload_in,
    input wire logic [ctu_pkg::CTU_NUM_TMR-1:0] tmr_wr_in,
    input wire logic [ctu_pkg::CTU_TW-1:0] tmr_wr_data_in,
    input wire logic aux_ovf_in,
    input wire logic [ctu_pkg::CTU_NUM_TMR-1:0] ext_count_in,
    input wire logic [ctu_pkg::CTU_NUM_CH-1:0][2:0] ch_mode_in,
    input wire logic [ctu_pkg::CTU_NUM_CH-1:0] ch_tmr_sel_in,
    input wire logic [ctu_pkg::CTU_NUM_CH-1:0][1:0] ch_edge_in,
    input wire logic [ctu_pkg::CTU_NUM_CH-1:0] ch_single_in,
    input wire logic [ctu_pkg::CTU_NUM_CH-1:0] ch_rearm_in,
    input wire logic ch_wr_in,
    input wire logic [3:0] ch_wr_idx_in,
    input wire logic [ctu_pkg::CTU_TW-1:0] ch_wr_data_in,
    input wire logic [ctu_pkg::CTU_NUM_CH-1:0] pin_in,
    output logic [ctu_pkg::CTU_NUM_CH-1:0] pin_out,
    output logic [ctu_pkg::CTU_NUM_CH-1:0] pin_oe_n_out,
    output logic [ctu_pkg::CTU_NUM_CH-1:0] irq_out,
    output logic [ctu_pkg::CTU_NUM_CH-1:0] ch_armed_out,
    output logic [ctu_pkg::CTU_NUM_CH-1:0][ctu_pkg::CTU_TW-1:0] ch_val_out,
    output logic [ctu_pkg::CTU_NUM_TMR-1:0][ctu_pkg::CTU_TW-1:0] tmr_val_out,
    output logic [ctu_pkg::CTU_NUM_TMR-1:0] tmr_ovf_out
);
    import ctu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // decoders shared by every channel

    function automatic logic is_cmp(input logic [2:0] mode);
        is_cmp = (mode == CTU_MODE_CMP0) || (mode == CTU_MODE_CMP1) ||
                 (mode == CTU_MODE_CMP2) || (mode == CTU_MODE_CMP3) ||
                 (mode == CTU_MODE_DOUBLE);
    endfunction

    // pin is driven only in modes that act on it
    function automatic logic drives_pin(input logic [2:0] mode);
        drives_pin = (mode == CTU_MODE_CMP1) || (mode == CTU_MODE_CMP3) ||
                     (mode == CTU_MODE_DOUBLE);
    endfunction

    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        case (sel)
            CTU_EDGE_RISE: edge_hit = rise;
            CTU_EDGE_FALL: edge_hit = fall;
            CTU_EDGE_BOTH: edge_hit = rise || fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // low-bit mask of the shared prescaler; stagger adds three more bits
    function automatic logic [CTU_PRE_W-1:0] pre_mask(input logic [2:0] presc,
                                                      input logic stag);
        logic [3:0] sh;
        sh = {1'b0, presc} + (stag ? CTU_STAGGER_SHIFT : 4'h0);
        pre_mask = ~({CTU_PRE_W{1'b1}} << sh);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // count sources

    logic [CTU_PRE_W-1:0] pre_cnt_q;
    logic [CTU_NUM_TMR-1:0] ext_prev_q;
    logic [CTU_NUM_TMR-1:0] pre_tick;
    logic [CTU_NUM_TMR-1:0] tmr_tick;
    logic [CTU_NUM_TMR-1:0] tmr_upd;
    logic [CTU_NUM_TMR-1:0][CTU_TW-1:0] tval;

    // one free-running prescaler serves both timers, so their ticks stay phase aligned
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pre_cnt_q <= '0;
        end else if (ce_in) begin
            pre_cnt_q <= pre_cnt_q + 10'h001;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ext_prev_q <= '0;
        end else if (ce_in) begin
            ext_prev_q <= ext_count_in;
        end
    end

    generate
        for (genvar t = 0; t < CTU_NUM_TMR; t++) begin : g_tmr
            logic [CTU_PRE_W-1:0] mask;
            assign mask = pre_mask(tmr_presc_in[t], stagger_in);
            assign pre_tick[t] = (pre_cnt_q & mask) == mask;

            always_comb begin
                case (tmr_src_in[t])
                    CTU_SRC_PRESC: tmr_tick[t] = pre_tick[t];
                    CTU_SRC_AUX: tmr_tick[t] = aux_ovf_in;
                    CTU_SRC_EXT: tmr_tick[t] = ext_count_in[t] && !ext_prev_q[t];
                    default: tmr_tick[t] = 1'b0;
                endcase
            end

            ctu_timer u_timer (
                .clk_sys_in(clk_sys_in),
                .rst_in(rst_in),
                .ce_in(ce_in),
                .run_in(tmr_run_in[t]),
                .tick_in(tmr_tick[t]),
                .wr_in(tmr_wr_in[t]),
                .wr_data_in(tmr_wr_data_in),
                .reload_in(tmr_reload_in[t]),
                .val_out(tval[t]),
                .upd_out(tmr_upd[t]),
                .ovf_out(tmr_ovf_out[t])
            );

            assign tmr_val_out[t] = tval[t];

            a_stagger_res: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (pre_tick[t] && stagger_in) |-> (pre_cnt_q[2:0] == CTU_STAGGER_PHASE))
                else $error("staggered tick off the eight-cycle grid");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel compare qualification, needed before the pin logic

    logic [CTU_NUM_CH-1:0] act;
    logic [CTU_NUM_CH-1:0] done_q;
    logic [CTU_NUM_CH-1:0] armed_q;

    generate
        for (genvar i = 0; i < CTU_NUM_CH; i++) begin : g_act
            logic hit;
            logic once;
            // a match counts only in the cycle the timer has just advanced
            assign hit = tmr_upd[ch_tmr_sel_in[i]] &&
                         (ch_val_out[i] == tval[ch_tmr_sel_in[i]]);
            assign once = (ch_mode_in[i] == CTU_MODE_CMP2) ||
                          (ch_mode_in[i] == CTU_MODE_CMP3);
            assign act[i] = is_cmp(ch_mode_in[i]) && hit && armed_q[i] &&
                            !(once && done_q[i]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // channels

    generate
        for (genvar i = 0; i < CTU_NUM_CH; i++) begin : g_ch
            logic [2:0] mode;
            logic sel;
            logic ovf;
            logic trig;
            logic dbl_act;
            logic pin_prev_q;
            logic [CTU_TW-1:0] val_q;
            logic pin_q;
            logic oe_n_q;
            logic irq_q;

            assign mode = ch_mode_in[i];
            assign sel = ch_tmr_sel_in[i];
            assign ovf = tmr_ovf_out[sel];
            assign trig = (mode == CTU_MODE_CAPTURE) &&
                          edge_hit(ch_edge_in[i], pin_prev_q, pin_in[i]);

            // lower channel of a pair also toggles on its partner's match
            if (i < CTU_PAIR_OFS) begin : g_lo
                assign dbl_act = act[i] || (act[i + CTU_PAIR_OFS] &&
                                 ch_mode_in[i + CTU_PAIR_OFS] == CTU_MODE_DOUBLE);
            end else begin : g_hi
                // an upper pair member never toggles its own pin in double-register mode
                assign dbl_act = 1'b0;
            end

            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    pin_prev_q <= 1'b0;
                end else if (ce_in) begin
                    pin_prev_q <= pin_in[i];
                end
            end

            // a capture in the same cycle as a software write wins
            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    val_q <= CTU_CH_RST;
                end else if (ce_in) begin
                    if (trig) begin
                        val_q <= tval[sel];
                    end else if (ch_wr_in && ch_wr_idx_in == 4'(i)) begin
                        val_q <= ch_wr_data_in;
                    end
                end
            end

            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    irq_q <= 1'b0;
                end else if (ce_in) begin
                    irq_q <= trig || act[i];
                end
            end

            // once-per-period latch: a new match in the overflow cycle still sets it;
            // only modes 2 and 3 set it, so a channel switched into them keeps its first event
            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    done_q[i] <= 1'b0;
                end else if (ce_in) begin
                    if (act[i] && (mode == CTU_MODE_CMP2 || mode == CTU_MODE_CMP3)) begin
                        done_q[i] <= 1'b1;
                    end else if (ovf) begin
                        done_q[i] <= 1'b0;
                    end
                end
            end

            // disarm beats a re-arm arriving in the same cycle
            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    armed_q[i] <= 1'b1;
                end else if (ce_in) begin
                    if (act[i] && ch_single_in[i]) begin
                        armed_q[i] <= 1'b0;
                    end else if (ch_rearm_in[i]) begin
                        armed_q[i] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    pin_q <= 1'b0;
                    oe_n_q <= 1'b1;
                end else if (ce_in) begin
                    oe_n_q <= !drives_pin(mode);
                    case (mode)
                        CTU_MODE_CMP1: begin
                            if (act[i]) begin
                                pin_q <= !pin_q;
                            end
                        end
                        CTU_MODE_CMP3: begin
                            // a match in the overflow cycle opens the new period high
                            if (act[i]) begin
                                pin_q <= 1'b1;
                            end else if (ovf) begin
                                pin_q <= 1'b0;
                            end
                        end
                        CTU_MODE_DOUBLE: begin
                            if (dbl_act) begin
                                pin_q <= !pin_q;
                            end
                        end
                        default: begin
                            pin_q <= pin_q;
                        end
                    endcase
                end
            end

            assign ch_val_out[i] = val_q;
            assign pin_out[i] = pin_q;
            assign pin_oe_n_out[i] = oe_n_q;
            assign irq_out[i] = irq_q;
            assign ch_armed_out[i] = armed_q[i];

            ////////////////////////////////////////////////////////////////////////
            // checks

            sequence s_capture_edge;
                ce_in && trig;
            endsequence

            sequence s_capture_done(logic [CTU_TW-1:0] tv);
                (val_q == tv) && irq_q;
            endsequence

            a_capture_latch: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                s_capture_edge |=> (val_q == $past(tval[sel])))
                else $error("capture did not latch timer value");

            a_capture_irq: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                s_capture_edge |=> irq_q)
                else $error("capture did not raise the interrupt");

            a_capture_edge: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && mode == CTU_MODE_CAPTURE && ch_edge_in[i] == CTU_EDGE_RISE &&
                 !pin_prev_q && pin_in[i] && !(ch_wr_in && ch_wr_idx_in == 4'(i)))
                |=> s_capture_done($past(tval[sel])))
                else $error("rising edge not captured");

            a_toggle_match: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && mode == CTU_MODE_CMP1 && act[i]) |=> (pin_q != $past(pin_q)))
                else $error("mode 1 match did not toggle the pin");

            a_mode0_pin_quiet: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (mode == CTU_MODE_CMP0) |=> (pin_q == $past(pin_q)))
                else $error("mode 0 moved the pin");

            a_mode2_once: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && mode == CTU_MODE_CMP2 && done_q[i] && !trig) |=> !irq_q)
                else $error("mode 2 raised a second interrupt in one period");

            a_mode3_clear: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && mode == CTU_MODE_CMP3 && ovf && !act[i]) |=> !pin_q)
                else $error("mode 3 pin not cleared on overflow");

            a_single_disarm: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && act[i] && ch_single_in[i]) |=> (!armed_q[i] && !act[i]))
                else $error("single event did not disarm the channel");

            a_mode3_set: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && mode == CTU_MODE_CMP3 && act[i]) |=> pin_q)
                else $error("mode 3 match did not set the pin");

            a_double_toggle: assert property (
                @(posedge clk_sys_in) disable iff (rst_in)
                (ce_in && mode == CTU_MODE_DOUBLE && dbl_act) |=> (pin_q != $past(pin_q)))
                else $error("double-register match did not toggle the pin");
        end
    endgenerate
endmodule

// file: ctu_pin_model.sv
// far-side model of the channel pins and the external count inputs
`timescale 1ns/1ps
module ctu_pin_model (
    input wire logic clk_in,
    input wire logic [15:0] drv_in,
    input wire logic [15:0] pin_out_in,
    input wire logic [15:0] pin_oe_n_in,
    input wire logic [1:0] ext_req_in,
    output logic [15:0] pin_in_out,
    output logic [1:0] ext_count_out
);
    // a pin the unit drives reads back its own level, otherwise the outside source wins
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pin_in_out[i] = pin_oe_n_in[i] ? drv_in[i] : pin_out_in[i];
        end
    end
    // count pulses arrive one cycle late, as from a synchronised outside source
    always_ff @(posedge clk_in) begin
        ext_count_out <= ext_req_in;
    end
endmodule

// file: ctu_capture_compare_test.sv
// self-checking bench for the sixteen-channel capture/compare unit
`timescale 1ns/1ps
module ctu_capture_compare_test;
import ctu_pkg::*;
logic clk_sys_in = 0, rst_in = 1, ce_in = 1, stagger_in = 0, aux_ovf_in = 0, ch_wr_in = 0;
logic [1:0] tmr_run_in = 0, tmr_wr_in = 0, ext_req = 0, ext_count, tmr_ovf_out;
logic [1:0][1:0] tmr_src_in = 0;
logic [1:0][2:0] tmr_presc_in = 0;
logic [1:0][15:0] tmr_reload_in = 0, tmr_val_out;
logic [15:0] tmr_wr_data_in = 0, ch_wr_data_in = 0, drv = 0, pin_in, pin_out;
logic [3:0] ch_wr_idx_in = 0;
logic [15:0][2:0] ch_mode_in = 0;
logic [15:0][1:0] ch_edge_in = 0;
logic [15:0] ch_tmr_sel_in = 0, ch_single_in = 0, ch_rearm_in = 0;
logic [15:0] pin_oe_n_out, irq_out, ch_armed_out;
logic [15:0][15:0] ch_val_out;
logic [2:0] mlist [3] = '{CTU_MODE_CMP0, CTU_MODE_CMP1, CTU_MODE_CMP2};
logic [15:0] v, r;
logic p;
int failures = 0, comparisons = 0, n, k, ch, t;
ctu_capture_compare dut (.*, .ext_count_in(ext_count));
ctu_pin_model pm (.clk_in(clk_sys_in), .drv_in(drv), .pin_out_in(pin_out),
    .pin_oe_n_in(pin_oe_n_out), .ext_req_in(ext_req), .pin_in_out(pin_in),
    .ext_count_out(ext_count));
initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
end
////////////////////////////////////////////////////////////////////////////////
task cyc(input int c);
    repeat (c) @(posedge clk_sys_in);
    #1;
endtask
task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
        failures++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task print_verdict;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
// bounded wait for an irq (ovf=0) or an overflow pulse (ovf=1)
task wait_hi(input int ovf, input int i);
    for (int c = 0; c < 300; c++) begin
        cyc(1);
        if ((ovf ? tmr_ovf_out[i] : irq_out[i]) === 1'b1) return;
    end
    failures++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict;
endtask
task set_tmr(input int i, input logic [15:0] d);
    tmr_wr_data_in = d;
    tmr_wr_in[i] = 1'b1;
    cyc(1);
    tmr_wr_in = 2'b00;
endtask
task set_ch(input int i, input logic [15:0] d);
    ch_wr_in = 1'b1;
    ch_wr_idx_in = 4'(i);
    ch_wr_data_in = d;
    cyc(1);
    ch_wr_in = 1'b0;
endtask
// cycles between two timer steps, the first step may be partial
task gap(output int c);
    c = 0;
    for (int s = 0; s < 2; s++) begin
        v = tmr_val_out[0];
        c = 0;
        while (tmr_val_out[0] === v && c < 100) begin
            cyc(1);
            c++;
        end
        if (c >= 100) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, tmr_val_out[0], v + 16'h1);
            print_verdict;
        end
    end
endtask
// timer 0 stopped at ffe0 (period ffe0..ffff), channel loaded, mode set
task cmp_setup(input int i, input logic [2:0] m, input logic [15:0] d);
    tmr_run_in = 2'b00;
    tmr_src_in = '0;
    tmr_presc_in = '0;
    tmr_reload_in[0] = 16'hffe0;
    ch_mode_in = '0;
    ch_tmr_sel_in = '0;
    set_tmr(0, 16'hffe0);
    set_ch(i, d);
    ch_mode_in[i] = m;
    cyc(2);
endtask
task count_irq(input int i, input int c);
    n = 0;
    repeat (c) begin
        cyc(1);
        n += (irq_out[i] === 1'b1);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(32'h2667));
    repeat (20) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    cyc(1);
    chk(pin_oe_n_out, 16'hffff);
    chk(ch_armed_out, 16'hffff);
    chk(tmr_val_out[0], CTU_TMR_RST);
    $display("test reset done");
    tmr_run_in = 2'b01;
    for (int j = 0; j < 4; j++) begin
        tmr_presc_in[0] = 3'(j % 3);
        stagger_in = (j == 3);
        gap(n);
        chk(n[15:0], (j == 3) ? 16'h8 : 16'(1 << j));
    end
    stagger_in = 1'b0;
    $display("test prescaler done");
    tmr_src_in = {CTU_SRC_EXT, CTU_SRC_AUX};
    tmr_run_in = 2'b11;
    set_tmr(0, 16'h0100);
    cyc(1);
    set_tmr(1, 16'h0200);
    k = $urandom_range(3, 9);
    repeat (k) begin
        aux_ovf_in = 1'b1;
        ext_req = 2'b10;
        cyc(1);
        aux_ovf_in = 1'b0;
        ext_req = 2'b00;
        cyc($urandom_range(2, 5));
    end
    cyc(3);
    chk(tmr_val_out[0], 16'h0100 + k[15:0]);
    chk(tmr_val_out[1], 16'h0200 + k[15:0]);
    $display("test count sources done");
    tmr_src_in = '0;
    r = 16'($urandom_range(0, 16'hffef));
    tmr_reload_in[0] = r;
    set_tmr(0, 16'hfffc);
    wait_hi(1, 0);
    chk(tmr_val_out[0], r);
    cyc(1);
    chk(tmr_val_out[0], r + 16'h1);
    ce_in = 1'b0;
    v = tmr_val_out[0];
    cyc(4);
    chk(tmr_val_out[0], v);
    ce_in = 1'b1;
    $display("test reload done");
    tmr_run_in = 2'b00;
    for (int e = 1; e < 4; e++) begin
        ch = $urandom_range(0, 15);
        t = $urandom_range(0, 1);
        v = 16'($urandom);
        set_tmr(t, v);
        ch_mode_in = '0;
        ch_mode_in[ch] = CTU_MODE_CAPTURE;
        ch_tmr_sel_in[ch] = t[0];
        ch_edge_in[ch] = 2'(e);
        cyc(2);
        drv[ch] = 1'b1;
        count_irq(ch, 3);
        chk(n[15:0], 16'(e != 2));
        drv[ch] = 1'b0;
        count_irq(ch, 3);
        chk(n[15:0], 16'(e != 1));
        chk(ch_val_out[ch], v);
    end
    $display("test capture done");
    foreach (mlist[j]) begin
        ch = $urandom_range(0, 15);
        cmp_setup(ch, mlist[j], 16'hffe4);
        p = pin_out[ch];
        tmr_run_in = 2'b01;
        wait_hi(0, ch);
        chk(pin_out[ch], p ^ (mlist[j] == CTU_MODE_CMP1));
        chk(pin_oe_n_out[ch], mlist[j] != CTU_MODE_CMP1);
        set_ch(ch, 16'hffec);
        count_irq(ch, 14);
        chk(n[15:0], 16'(mlist[j] != CTU_MODE_CMP2));
        chk(pin_out[ch], p);
    end
    $display("test compare modes done");
    ch = $urandom_range(0, 15);
    cmp_setup(ch, CTU_MODE_CMP3, 16'hffe4);
    tmr_run_in = 2'b01;
    wait_hi(0, ch);
    chk(pin_out[ch], 1'b1);
    set_ch(ch, 16'hffec);
    count_irq(ch, 14);
    chk(n[15:0], 16'h0);
    wait_hi(1, 0);
    cyc(1);
    chk(pin_out[ch], 1'b0);
    $display("test set and clear done");
    ch_single_in[ch] = 1'b1;
    cmp_setup(ch, CTU_MODE_CMP0, 16'hffe4);
    tmr_run_in = 2'b01;
    wait_hi(0, ch);
    chk(ch_armed_out[ch], 1'b0);
    set_ch(ch, 16'hffec);
    count_irq(ch, 14);
    chk(n[15:0], 16'h0);
    ch_rearm_in[ch] = 1'b1;
    cyc(1);
    ch_rearm_in = '0;
    cyc(1);
    chk(ch_armed_out[ch], 1'b1);
    ch_single_in = '0;
    $display("test single event done");
    ch = $urandom_range(0, 7);
    cmp_setup(ch, CTU_MODE_DOUBLE, 16'hffe4);
    set_ch(ch + 8, 16'hffe8);
    ch_mode_in[ch + 8] = CTU_MODE_DOUBLE;
    cyc(2);
    p = pin_out[ch];
    tmr_run_in = 2'b01;
    wait_hi(0, ch);
    chk(pin_out[ch], !p);
    cyc(8);
    chk(pin_out[ch], p);
    $display("test double register done");
    print_verdict;
end
endmodule
